// file: hw/ccm_unit.sv
// Purpose: capture/compare/pwm unit with mode select, full capture path and axi4-lite registers
// Assumes: timer counts come from logic on aclk; capture pin is asynchronous
// Notes: one unit; SECOND_UNIT selects the converter-start variant of the special event
`timescale 1ns/100ps
`default_nettype none
`include "ccm_params.svh"
module ccm_unit #(
  parameter bit SECOND_UNIT = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] first_timer_count,
  input wire logic [7:0] pwm_timer_count,
  input wire logic [1:0] pwm_fine_count,
  input wire logic pwm_period_match,
  input wire logic adc_enabled,
  input wire logic port_direction_bit,
  input wire logic port_data_latch,
  input wire logic capture_pin_i,
  output logic capture_pin_o,
  output logic capture_pin_oe,
  output logic unit_event_flag,
  output logic timer_clear,
  output logic adc_start
);
  import ccm_pkg::*;

  ccm_wstate_t ws_q, ws_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [5:0] ctrl_q, ctrl_d;
  logic [7:0] duty_upper_q, duty_upper_d;
  logic [15:0] cap_pair_q, cap_pair_d;
  logic [9:0] duty_buf_q, duty_buf_d;
  logic flag_q, flag_d;
  logic out_q, out_d;
  logic match_q, match_d;
  logic pin_prev_q, pin_prev_d;
  logic wr_fire, aw_take, w_take, ar_take;
  logic [7:0] wr_addr, wr_word;
  logic [31:0] wr_data;
  logic wr_b0, wr_hit, flag_clr;
  ccm_mode_t mode;
  logic is_off, is_cap, is_cmp, is_pwm;
  logic pin_sync, pin_level, rise_evt, fall_evt, edge_evt, cap_fire;
  logic match_now, cmp_evt;
  logic [9:0] pwm_duty;
  logic [3:0] ps_count;
  ccm_psel_t ps_sel;
  logic [7:0] rd_word;

  // mode decode from the stored control field
  always_comb begin
    mode = ctrl_q[`CCM_MODE_MSB:`CCM_MODE_LSB];
    is_off = (mode == `CCM_MODE_OFF);
    is_cap = (mode[3:2] == `CCM_GRP_CAP);
    is_cmp = (mode[3:2] == `CCM_GRP_CMP);
    is_pwm = (mode[3:2] == `CCM_GRP_PWM);
    pwm_duty = {duty_upper_q, ctrl_q[`CCM_DLOW_MSB:`CCM_DLOW_LSB]};
    case (mode[1:0])
      2'h2: ps_sel = CCM_PS_DIV4;
      2'h3: ps_sel = CCM_PS_DIV16;
      default: ps_sel = CCM_PS_DIV1;
    endcase
  end

  // pin path: synchronised pad, or the port latch when the pin is an output
  ccm_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d(capture_pin_i),
    .q(pin_sync)
  );
  always_comb begin
    pin_level = port_direction_bit ? pin_sync : port_data_latch;
    // history survives mode changes, so a change raises no false capture
    rise_evt = pin_level & ~pin_prev_q;
    fall_evt = ~pin_level & pin_prev_q;
    edge_evt = is_cap & ((mode == `CCM_MODE_CAP_FALL) ? fall_evt : rise_evt);
    pin_prev_d = pin_level;
  end

  ccm_prescale u_ps (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .clear(~is_cap),
    .edge_evt(edge_evt),
    .sel(ps_sel),
    .fire(cap_fire),
    .count(ps_count)
  );

  // compare match: one event per entry into equality
  always_comb begin
    match_now = is_cmp & (first_timer_count == cap_pair_q);
    match_d = match_now;
    cmp_evt = match_now & ~match_q;
    timer_clear = cmp_evt & (mode == `CCM_MODE_CMP_SPEC);
    adc_start = timer_clear & SECOND_UNIT & adc_enabled;
  end

  // axi handshakes; ready is withheld while ce is low
  always_comb begin
    s_axi_awready = ce & ((ws_q == CCM_WS_IDLE) | (ws_q == CCM_WS_W));
    s_axi_wready = ce & ((ws_q == CCM_WS_IDLE) | (ws_q == CCM_WS_AW));
    s_axi_arready = ce & ~rvalid_q;
    aw_take = s_axi_awvalid & s_axi_awready;
    w_take = s_axi_wvalid & s_axi_wready;
    ar_take = s_axi_arvalid & s_axi_arready;
    s_axi_bvalid = (ws_q == CCM_WS_RESP);
    s_axi_bresp = bresp_q;
    s_axi_rvalid = rvalid_q;
    s_axi_rdata = rdata_q;
    s_axi_rresp = rresp_q;
  end

  // write channel state
  always_comb begin
    ws_d = ws_q;
    awaddr_d = aw_take ? s_axi_awaddr : awaddr_q;
    wdata_d = w_take ? s_axi_wdata : wdata_q;
    wstrb0_d = w_take ? s_axi_wstrb[0] : wstrb0_q;
    wr_fire = 1'b0;
    case (ws_q)
      CCM_WS_IDLE: begin
        if (aw_take & w_take) begin
          wr_fire = 1'b1;
          ws_d = CCM_WS_RESP;
        end else if (aw_take) begin
          ws_d = CCM_WS_AW;
        end else if (w_take) begin
          ws_d = CCM_WS_W;
        end
      end
      CCM_WS_AW: begin
        if (w_take) begin
          wr_fire = 1'b1;
          ws_d = CCM_WS_RESP;
        end
      end
      CCM_WS_W: begin
        if (aw_take) begin
          wr_fire = 1'b1;
          ws_d = CCM_WS_RESP;
        end
      end
      CCM_WS_RESP: begin
        if (s_axi_bready) begin
          ws_d = CCM_WS_IDLE;
        end
      end
      default: ws_d = CCM_WS_IDLE;
    endcase
    wr_addr = aw_take ? s_axi_awaddr : awaddr_q;
    wr_data = w_take ? s_axi_wdata : wdata_q;
    wr_b0 = w_take ? s_axi_wstrb[0] : wstrb0_q;
    wr_word = {wr_addr[7:2], 2'b00};
    wr_hit = (wr_word == `CCM_OFF_CTRL) | (wr_word == `CCM_OFF_DUTY) | (wr_word == `CCM_OFF_CAPL) |
             (wr_word == `CCM_OFF_CAPH) | (wr_word == `CCM_OFF_STAT);
    bresp_d = bresp_q;
    if (wr_fire) begin
      bresp_d = wr_hit ? `CCM_RESP_OKAY : `CCM_RESP_SLVERR;
    end
  end

  // read channel: data registered at the address handshake
  always_comb begin
    rd_word = {s_axi_araddr[7:2], 2'b00};
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q & s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d = `CCM_RESP_OKAY;
      case (rd_word)
        `CCM_OFF_CTRL: rdata_d = {26'h0, ctrl_q};
        `CCM_OFF_DUTY: rdata_d = {24'h0, duty_upper_q};
        `CCM_OFF_CAPL: rdata_d = {24'h0, cap_pair_q[7:0]};
        // in pwm the high byte shows the buffered duty, read only
        `CCM_OFF_CAPH: rdata_d = {24'h0, is_pwm ? duty_buf_q[9:2] : cap_pair_q[15:8]};
        `CCM_OFF_STAT: rdata_d = {31'h0, flag_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = `CCM_RESP_SLVERR;
        end
      endcase
    end
  end

  // unit state: control, capture pair, flag, output latch, pwm buffer
  always_comb begin
    ctrl_d = ctrl_q;
    duty_upper_d = duty_upper_q;
    cap_pair_d = cap_pair_q;
    duty_buf_d = duty_buf_q;
    out_d = out_q;
    flag_clr = 1'b0;
    if (wr_fire & wr_b0) begin
      case (wr_word)
        `CCM_OFF_CTRL: ctrl_d = wr_data[5:0];
        `CCM_OFF_DUTY: duty_upper_d = wr_data[7:0];
        `CCM_OFF_CAPL: cap_pair_d[7:0] = wr_data[7:0];
        `CCM_OFF_CAPH: begin
          if (!is_pwm) begin
            cap_pair_d[15:8] = wr_data[7:0];
          end
        end
        `CCM_OFF_STAT: flag_clr = wr_data[`CCM_STAT_FLAG_BIT];
        default: ctrl_d = ctrl_q;
      endcase
    end
    if (cap_fire) begin
      cap_pair_d = first_timer_count;
    end
    if (cmp_evt & (mode == `CCM_MODE_CMP_SET)) begin
      out_d = 1'b1;
    end
    if (cmp_evt & (mode == `CCM_MODE_CMP_CLR)) begin
      out_d = 1'b0;
    end
    // pwm: clear on duty match, reload at period end and set unless the new duty is zero (period end wins)
    if (is_pwm) begin
      if ({pwm_timer_count, pwm_fine_count} == duty_buf_q) begin
        out_d = 1'b0;
      end
      if (pwm_period_match) begin
        duty_buf_d = pwm_duty;
        out_d = (pwm_duty != 10'h000);
      end
    end
    // writing mode zero parks the unit; the prescaler clears via is_cap
    if (is_off) begin
      out_d = 1'b0;
      duty_buf_d = 10'h000;
    end
    // the special event clears the timer, raises the flag and, on the second unit with adc_enabled high, starts the converter; no overflow indication here
    flag_d = cap_fire | cmp_evt | (flag_q & ~flag_clr);
    unit_event_flag = flag_q;
    capture_pin_o = out_q;
    capture_pin_oe = ~port_direction_bit;
  end

  // one register bank; ce freezes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_q <= CCM_WS_IDLE;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb0_q <= 1'b0;
      bresp_q <= `CCM_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `CCM_RESP_OKAY;
      ctrl_q <= `CCM_CTRL_RST;
      duty_upper_q <= 8'h00;
      cap_pair_q <= 16'h0000;
      duty_buf_q <= 10'h000;
      flag_q <= 1'b0;
      out_q <= 1'b0;
      match_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else if (ce) begin
      ws_q <= ws_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
      duty_upper_q <= duty_upper_d;
      cap_pair_q <= cap_pair_d;
      duty_buf_q <= duty_buf_d;
      flag_q <= flag_d;
      out_q <= out_d;
      match_q <= match_d;
      pin_prev_q <= pin_prev_d;
    end
  end

  // checks, all but a_cap_edge and a_spec sampled only on enabled cycles
  property p_duty_latch;
    @(posedge aclk) disable iff (!aresetn) (ce && is_pwm && pwm_period_match) |=> (duty_buf_q == $past(pwm_duty));
  endproperty
  a_duty_latch: assert property (p_duty_latch) else $error("duty not latched at period end");
  property p_off_parked;
    @(posedge aclk) disable iff (!aresetn) (is_off && ce) |=> (!out_q && duty_buf_q == 10'h000 && ps_count == 4'h0);
  endproperty
  a_off_parked: assert property (p_off_parked) else $error("unit not parked in mode zero");
  property p_cap_edge;
    @(posedge aclk) disable iff (!aresetn) cap_fire |-> (mode == `CCM_MODE_CAP_FALL) ? fall_evt : rise_evt;
  endproperty
  a_cap_edge: assert property (p_cap_edge) else $error("capture on wrong edge");
  property p_cmp_set;
    @(posedge aclk) disable iff (!aresetn) (ce && cmp_evt && mode == `CCM_MODE_CMP_SET) |=> (out_q && flag_q);
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("set-on-match failed");
  property p_cmp_clr;
    @(posedge aclk) disable iff (!aresetn) (ce && cmp_evt && mode == `CCM_MODE_CMP_CLR) |=> (!out_q && flag_q);
  endproperty
  a_cmp_clr: assert property (p_cmp_clr) else $error("clear-on-match failed");
  property p_cmp_soft;
    @(posedge aclk) disable iff (!aresetn)
      (ce && cmp_evt && mode[3:1] == 3'h5) |=> (flag_q && out_q == $past(out_q));
  endproperty
  a_cmp_soft: assert property (p_cmp_soft) else $error("flag-only match touched output");
  // the trigger must come from a fresh match in mode 1011; the converter start follows only on the second unit
  property p_spec;
    @(posedge aclk) disable iff (!aresetn)
      (timer_clear || adc_start) |-> (timer_clear && mode == `CCM_MODE_CMP_SPEC && !match_q &&
                                      first_timer_count == cap_pair_q && adc_start == (SECOND_UNIT && adc_enabled));
  endproperty
  a_spec: assert property (p_spec) else $error("special event or converter start wrong");
  property p_capture;
    @(posedge aclk) disable iff (!aresetn) (ce && cap_fire) |=> (cap_pair_q == $past(first_timer_count) && flag_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value or flag wrong");
  property p_flag_hold;
    @(posedge aclk) disable iff (!aresetn) (ce && flag_q && !flag_clr) |=> flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without software clear");
  property p_ps_clear;
    @(posedge aclk) disable iff (!aresetn) (ce && !is_cap) |=> (ps_count == 4'h0);
  endproperty
  a_ps_clear: assert property (p_ps_clear) else $error("prescaler not cleared outside capture");
  c_capture: cover property (@(posedge aclk) disable iff (!aresetn) cap_fire && ps_sel == CCM_PS_DIV16);
  c_compare: cover property (@(posedge aclk) disable iff (!aresetn) timer_clear);
  c_pwm: cover property (@(posedge aclk) disable iff (!aresetn) is_pwm && pwm_period_match && pwm_duty != 10'h000);
endmodule
`default_nettype wire

// file: hw/ccm_params.svh
// Purpose: offsets, field positions, reset values and codes of the capture/compare unit
// Assumes: included by bare name from every file that needs a constant
// Notes: definitions only
`ifndef CCM_PARAMS_SVH
`define CCM_PARAMS_SVH

// register byte offsets on the axi4-lite port
`define CCM_OFF_CTRL 8'h00
`define CCM_OFF_DUTY 8'h04
`define CCM_OFF_CAPL 8'h08
`define CCM_OFF_CAPH 8'h0c
`define CCM_OFF_STAT 8'h10

// control register fields
`define CCM_MODE_MSB 3
`define CCM_MODE_LSB 0
`define CCM_DLOW_MSB 5
`define CCM_DLOW_LSB 4
`define CCM_CTRL_RST 6'h00
`define CCM_STAT_FLAG_BIT 0

// mode codes
`define CCM_MODE_OFF 4'h0
`define CCM_MODE_CAP_FALL 4'h4
`define CCM_MODE_CAP_RISE 4'h5
`define CCM_MODE_CAP_R4 4'h6
`define CCM_MODE_CAP_R16 4'h7
`define CCM_MODE_CMP_SET 4'h8
`define CCM_MODE_CMP_CLR 4'h9
`define CCM_MODE_CMP_SOFT 4'ha
`define CCM_MODE_CMP_SPEC 4'hb
`define CCM_GRP_CAP 2'h1
`define CCM_GRP_CMP 2'h2
`define CCM_GRP_PWM 2'h3

// prescaler terminal counts
`define CCM_PS4_LAST 4'h3
`define CCM_PS16_LAST 4'hf

// axi responses
`define CCM_RESP_OKAY 2'h0
`define CCM_RESP_SLVERR 2'h2

`endif

// file: hw/ccm_pkg.sv
// Purpose: shared types of the capture/compare unit
// Assumes: ccm_params.svh holds the numbers
// Notes: one-hot write-channel states
`include "ccm_params.svh"
package ccm_pkg;
  typedef logic [3:0] ccm_mode_t;
  typedef enum logic [1:0] {CCM_PS_DIV1 = 2'h0, CCM_PS_DIV4 = 2'h1, CCM_PS_DIV16 = 2'h2} ccm_psel_t;
  typedef enum logic [3:0] {
    CCM_WS_IDLE = 4'h1,
    CCM_WS_AW = 4'h2,
    CCM_WS_W = 4'h4,
    CCM_WS_RESP = 4'h8
  } ccm_wstate_t;
endpackage

// file: hw/ccm_sync.sv
// Purpose: two-flop synchroniser for the capture pin
// Assumes: d is asynchronous to aclk
// Notes: the first flop feeds only the second
`timescale 1ns/100ps
`default_nettype none
module ccm_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta_q;
  logic meta_d;
  logic q_d;

  // next values
  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end

  // two stages, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end
endmodule
`default_nettype wire

// file: hw/ccm_prescale.sv
// Purpose: edge prescaler for capture events (1, 4 or 16 edges)
// Assumes: edge_evt is a one-cycle pulse on aclk
// Notes: clear is a level; count holds across select changes
`timescale 1ns/100ps
`default_nettype none
`include "ccm_params.svh"
module ccm_prescale (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic clear,
  input wire logic edge_evt,
  input wire ccm_pkg::ccm_psel_t sel,
  output logic fire,
  output logic [3:0] count
);
  import ccm_pkg::*;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] last;

  // terminal count and next count
  always_comb begin
    case (sel)
      CCM_PS_DIV4: last = `CCM_PS4_LAST;
      CCM_PS_DIV16: last = `CCM_PS16_LAST;
      default: last = 4'h0;
    endcase
    fire = 1'b0;
    cnt_d = cnt_q;
    if (clear) begin
      cnt_d = 4'h0;
    end else if (edge_evt) begin
      // a count left from an older select may overshoot; fire and clear at the next edge
      if (cnt_q >= last) begin
        fire = 1'b1;
        cnt_d = 4'h0;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
    count = cnt_q;
  end

  // counter register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 4'h0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// file: verif/ccm_pin_model.sv
// Purpose: far-side source of edges on the capture pad
// Assumes: each edge lands 13 ns after drive is called, and the bench calls it on an aclk edge
// Notes: the level holds between edges, as a driven line does
`timescale 1ns/100ps
`default_nettype none
module ccm_pin_model (
  output logic pin
);
  initial pin = 1'b0;
  // the offset keeps each edge clear of the clock edge
  task automatic drive(input logic v);
    #13 pin = v;
  endtask
endmodule
`default_nettype wire

// file: verif/capture_compare_mode_and_capture_bench.sv
// Purpose: self-checking bench for the capture/compare unit
// Assumes: timer, pwm time base and port latch are driven by the bench on aclk
// Notes: one task per scenario; the event flag is watched on its port
`timescale 1ns/100ps
`default_nettype none
`include "ccm_params.svh"
module capture_compare_mode_and_capture_bench;
  import ccm_pkg::*;
  logic aclk, aresetn = 1'b0, ce = 1'b1, adc_enabled = 1'b1, pwm_period_match = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic port_direction_bit = 1'b1, port_data_latch = 1'b0;
  logic capture_pin_i, capture_pin_o, capture_pin_oe, unit_event_flag, timer_clear, adc_start;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pwm_timer_count = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, pwm_fine_count = 2'h0;
  logic [15:0] first_timer_count = 16'h0;
  int error_cnt, compares, cycle_cnt, clr_cnt, adc_cnt;

  ccm_unit i_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .first_timer_count, .pwm_timer_count, .pwm_fine_count, .pwm_period_match, .adc_enabled,
    .port_direction_bit, .port_data_latch, .capture_pin_i, .capture_pin_o, .capture_pin_oe,
    .unit_event_flag, .timer_clear, .adc_start);
  ccm_pin_model i_pin (.pin(capture_pin_i));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // hang guard and counts of special-event pulses
  always @(posedge aclk) begin
    cycle_cnt <= cycle_cnt + 1;
    if (timer_clear) clr_cnt <= clr_cnt + 1;
    if (adc_start) adc_cnt <= adc_cnt + 1;
    if (cycle_cnt == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  // switch off first so the prescaler restarts, then drop any false flag
  task automatic set_mode(input logic [3:0] m);
    wr(`CCM_OFF_CTRL, 32'h0);
    wr(`CCM_OFF_CTRL, 32'(m));
    wr(`CCM_OFF_STAT, 32'h1);
  endtask

  task automatic edge_to(input logic v, input logic [15:0] t);
    @(posedge aclk);
    first_timer_count <= t;
    i_pin.drive(v);
    cyc(5);
  endtask

  task automatic pulse(input logic [15:0] t);
    edge_to(1'b1, t);
    edge_to(1'b0, t);
  endtask

  task automatic chk_pair(input logic [15:0] e);
    rd(`CCM_OFF_CAPL);
    check(rd_data, {24'h0, e[7:0]});
    rd(`CCM_OFF_CAPH);
    check(rd_data, {24'h0, e[15:8]});
  endtask

  task automatic t_regs();
    rd(`CCM_OFF_CTRL);
    check(rd_data, 32'h0);
    rd(8'h14);
    check(32'(rsp), 32'(`CCM_RESP_SLVERR));
    check(rd_data, 32'h0);
    wr(8'h14, 32'h1);
    check(32'(rsp), 32'(`CCM_RESP_SLVERR));
    wr(`CCM_OFF_CTRL, 32'hff);
    rd(`CCM_OFF_CTRL);
    check(rd_data, 32'h3f);
    $display("done registers");
  endtask

  task automatic t_capture();
    for (int m = 0; m < 2; m++) begin
      set_mode(m[0] ? `CCM_MODE_CAP_RISE : `CCM_MODE_CAP_FALL);
      edge_to(1'b1, 16'h1111);
      chk1(unit_event_flag, m[0]);
      edge_to(1'b0, 16'h2222);
      chk1(unit_event_flag, 1'b1);
      chk_pair(m[0] ? 16'h1111 : 16'h2222);
    end
    $display("done capture edges");
  endtask

  task automatic t_prescale();
    int n;
    for (int k = 0; k < 2; k++) begin
      n = k ? 16 : 4;
      set_mode(k ? `CCM_MODE_CAP_R16 : `CCM_MODE_CAP_R4);
      pulse(16'h0);
      pulse(16'h0);
      set_mode(k ? `CCM_MODE_CAP_R16 : `CCM_MODE_CAP_R4);
      for (int i = 1; i <= n; i++) begin
        pulse(16'(i));
        chk1(unit_event_flag, i == n);
      end
      chk_pair(16'(n));
    end
    // a direct switch keeps the count, so a count of 6 fires at once under the divide-by-4 setting
    set_mode(`CCM_MODE_CAP_R16);
    for (int i = 0; i < 6; i++) begin
      pulse(16'h0);
    end
    wr(`CCM_OFF_CTRL, 32'(`CCM_MODE_CAP_R4));
    wr(`CCM_OFF_STAT, 32'h1);
    pulse(16'h00aa);
    chk1(unit_event_flag, 1'b1);
    chk_pair(16'h00aa);
    $display("done prescaler");
  endtask

  task automatic t_sticky();
    set_mode(`CCM_MODE_CAP_RISE);
    pulse(16'h0101);
    pulse(16'hbeef);
    cyc(20);
    chk_pair(16'hbeef);
    chk1(unit_event_flag, 1'b1);
    wr(`CCM_OFF_STAT, 32'h1);
    cyc(1);
    chk1(unit_event_flag, 1'b0);
    $display("done overwrite and flag");
  endtask

  task automatic t_latch();
    port_direction_bit <= 1'b0;
    set_mode(`CCM_MODE_CAP_RISE);
    chk1(capture_pin_oe, 1'b1);
    first_timer_count <= 16'h7777;
    port_data_latch <= 1'b1;
    cyc(4);
    chk1(unit_event_flag, 1'b1);
    chk_pair(16'h7777);
    port_direction_bit <= 1'b1;
    port_data_latch <= 1'b0;
    $display("done port latch");
  endtask

  task automatic t_compare();
    logic [3:0] codes[4] = '{4'h8, 4'ha, 4'h9, 4'hb};
    logic [3:0] pins = 4'b0011;
    int c0 = clr_cnt;
    wr(`CCM_OFF_CTRL, 32'h0);
    wr(`CCM_OFF_CAPL, 32'h34);
    wr(`CCM_OFF_CAPH, 32'h12);
    // direct switches, so each code acts on the pin the last one left
    for (int i = 0; i < 5; i++) begin
      wr(`CCM_OFF_CTRL, 32'(codes[i % 4]));
      wr(`CCM_OFF_STAT, 32'h1);
      first_timer_count <= 16'h1234;
      cyc(3);
      chk1(unit_event_flag, 1'b1);
      chk1(capture_pin_o, pins[i % 4]);
      first_timer_count <= 16'h0;
    end
    check(32'(clr_cnt - c0), 32'h1);
    check(32'(adc_cnt), 32'h0);
    wr(`CCM_OFF_CTRL, 32'h0);
    // the latch drops one edge after the zero mode lands
    cyc(1);
    chk1(capture_pin_o, 1'b0);
    $display("done compare");
  endtask

  task automatic t_pwm();
    logic [9:0] d;
    for (int k = 0; k < 2; k++) begin
      d = k ? 10'h00a : 10'h009;
      wr(`CCM_OFF_CTRL, 32'h0);
      wr(`CCM_OFF_DUTY, {24'h0, d[9:2]});
      wr(`CCM_OFF_CTRL, {26'h0, d[1:0], k ? 4'hf : 4'hc});
      {pwm_timer_count, pwm_fine_count} <= 10'h0;
      pwm_period_match <= 1'b1;
      @(posedge aclk);
      pwm_period_match <= 1'b0;
      cyc(2);
      chk1(capture_pin_o, 1'b1);
      {pwm_timer_count, pwm_fine_count} <= d - 10'h1;
      cyc(3);
      chk1(capture_pin_o, 1'b1);
      {pwm_timer_count, pwm_fine_count} <= d;
      cyc(3);
      chk1(capture_pin_o, 1'b0);
    end
    $display("done pwm");
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_capture();
    t_prescale();
    t_sticky();
    t_latch();
    t_compare();
    t_pwm();
    complete_run();
  end
endmodule
`default_nettype wire
